// ==== verilog/tmr16_core.sv ====
// 16-bit timer core: clock select, counter, three compare channels,
// input capture and the byte-wide register port with shared high byte.
// Assumes a single 25 MHz clock, one register strobe per cycle and pins
// that are asynchronous to that clock.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tmr16_defines.svh"

module tmr16_core (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic EXT_COUNT_INPUT_IN,
   input wire logic CAPTURE_INPUT_PIN_IN,
   input wire logic COMPARATOR_IN,
   output logic [7:0] RDATA_OUT,
   output logic [2:0] COMPARE_OUTPUT_PINS_OUT,
   output logic [7:0] IRQ_REQ_OUT
);

   // ----------------------------------------------------------------------
   // Mode decoding
   // ----------------------------------------------------------------------
   function automatic tmr16_pkg::tmr16_top_e top_sel(input logic [3:0] wgm);
      case (wgm)
         4'h1: top_sel = tmr16_pkg::TOP_8BIT;
         4'h2: top_sel = tmr16_pkg::TOP_9BIT;
         4'h3: top_sel = tmr16_pkg::TOP_10BIT;
         4'h4: top_sel = tmr16_pkg::TOP_OCA;
         4'hc: top_sel = tmr16_pkg::TOP_CAP;
         4'he: top_sel = tmr16_pkg::TOP_CAP;
         4'hf: top_sel = tmr16_pkg::TOP_OCA;
         default: top_sel = tmr16_pkg::TOP_MAX;
      endcase
   endfunction

   // Only the single-slope PWM modes are built; modes 4 and c wrap at OCR A or the capture value, the rest count up freely.
   function automatic logic is_pwm(input logic [3:0] wgm);
      case (wgm)
         4'h1, 4'h2, 4'h3, 4'he, 4'hf: is_pwm = 1'b1;
         default: is_pwm = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------------
   logic ext_rise;
   logic ext_fall;
   logic icp_rise;
   logic icp_fall;
   logic acmp_rise;
   logic acmp_fall;
   tmr16_pkg::tmr16_state_s st;
   tmr16_pkg::tmr16_state_s next_st;

   tmr16_pin_filter u_ext_filter (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .pin_in(EXT_COUNT_INPUT_IN),
      .filter_en_in(1'b0),
      .level_out(),
      .rise_out(ext_rise),
      .fall_out(ext_fall)
   );

   tmr16_pin_filter u_icp_filter (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .pin_in(CAPTURE_INPUT_PIN_IN),
      .filter_en_in(st.ctrl_b[`TMR16_CB_CAP_NC]),
      .level_out(),
      .rise_out(icp_rise),
      .fall_out(icp_fall)
   );

   tmr16_pin_filter u_acmp_filter (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .pin_in(COMPARATOR_IN),
      .filter_en_in(st.ctrl_b[`TMR16_CB_CAP_NC]),
      .level_out(),
      .rise_out(acmp_rise),
      .fall_out(acmp_fall)
   );

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   logic [3:0] wgm;
   logic pwm;
   logic ctc;
   tmr16_pkg::tmr16_top_e tsel;
   logic [15:0] top;
   logic tick;
   logic wrap;
   logic [7:0] set_flags;
   logic [7:0] clr_flags;
   logic [2:0] match;
   logic [2:0] force_cmp;
   logic [1:0] com;
   logic cap_edge_r;
   logic cap_edge_f;
   logic cap_event;
   logic oc_hit;
   logic [1:0] oc_idx;

   always_comb begin
      next_st = st;
      wgm = {st.ctrl_b[`TMR16_CB_WGM_HI], st.ctrl_a[`TMR16_CA_WGM_LO]};
      pwm = is_pwm(wgm);
      tsel = top_sel(wgm);
      ctc = !pwm && ((tsel == tmr16_pkg::TOP_OCA) || (tsel == tmr16_pkg::TOP_CAP));
      tick = 1'b0;
      set_flags = 8'h00;
      clr_flags = 8'h00;
      match = 3'h0;
      force_cmp = 3'h0;
      com = 2'h0;
      oc_hit = (ADDR_IN[7:3] == `TMR16_OFS_OCR_BASE) && (ADDR_IN[2:1] != 2'h3);
      oc_idx = ADDR_IN[2:1];

      case (tsel)
         tmr16_pkg::TOP_8BIT: top = `TMR16_TOP_8BIT;
         tmr16_pkg::TOP_9BIT: top = `TMR16_TOP_9BIT;
         tmr16_pkg::TOP_10BIT: top = `TMR16_TOP_10BIT;
         tmr16_pkg::TOP_OCA: top = st.ocr_act[0];
         tmr16_pkg::TOP_CAP: top = st.cap;
         default: top = `TMR16_MAX;
      endcase

      // The prescaler is frozen while the power gate is set, so the whole
      // timer stands still without losing its register contents.
      if (!st.power_gate) begin
         next_st.presc = 10'(st.presc + 10'h001);
         case (st.ctrl_b[`TMR16_CB_CS])
            `TMR16_CS_DIV1: tick = 1'b1;
            `TMR16_CS_DIV8: tick = &st.presc[2:0];
            `TMR16_CS_DIV64: tick = &st.presc[5:0];
            `TMR16_CS_DIV256: tick = &st.presc[7:0];
            `TMR16_CS_DIV1024: tick = &st.presc[9:0];
            `TMR16_CS_EXT_FALL: tick = ext_fall;
            `TMR16_CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
         endcase
      end

      // ------------------------------------------------------------------
      // Counter and overflow
      // ------------------------------------------------------------------
      wrap = (st.cnt == top);
      if (tick) begin
         next_st.cnt = wrap ? `TMR16_BOTTOM : st.cnt + 16'h0001;
         next_st.block = 1'b0;
         if (ctc ? (st.cnt == `TMR16_MAX) : wrap) begin
            set_flags[`TMR16_FLAG_TOV] = 1'b1;
         end
         // Buffered compare values take effect at TOP in PWM modes, so a
         // new duty cycle never produces a glitch mid-period.
         if (pwm && wrap) begin
            next_st.ocr_act = st.ocr_buf;
         end
      end

      // ------------------------------------------------------------------
      // Compare channels and waveform
      // ------------------------------------------------------------------
      for (int i = 0; i < 3; i++) begin
         com = st.ctrl_a[7 - 2 * i -: 2];
         match[i] = tick && !st.block && (st.cnt == st.ocr_act[i]);
         set_flags[`TMR16_FLAG_OCF0 + i] = match[i];
         force_cmp[i] = WR_IN && (ADDR_IN == `TMR16_OFS_CTRL_C) && !pwm
            && WDATA_IN[7 - i];
         if (com == 2'h0) begin
            next_st.wave[i] = 1'b0;
         end else if (pwm) begin
            if ((i == 0) && (tsel == tmr16_pkg::TOP_OCA)) begin
               next_st.wave[i] = 1'b0;
            end else begin
               if (match[i]) begin
                  next_st.wave[i] = (com == 2'h3);
               end
               if (tick && wrap) begin
                  next_st.wave[i] = (com == 2'h2);
               end
            end
         end else if (match[i] || force_cmp[i]) begin
            case (com)
               2'h1: next_st.wave[i] = !st.wave[i];
               2'h2: next_st.wave[i] = 1'b0;
               default: next_st.wave[i] = 1'b1;
            endcase
         end
      end

      // ------------------------------------------------------------------
      // Input capture
      // ------------------------------------------------------------------
      cap_edge_r = st.ctrl_b[`TMR16_CB_CAP_SRC] ? acmp_rise : icp_rise;
      cap_edge_f = st.ctrl_b[`TMR16_CB_CAP_SRC] ? acmp_fall : icp_fall;
      cap_event = !st.power_gate && (tsel != tmr16_pkg::TOP_CAP)
         && (st.ctrl_b[`TMR16_CB_CAP_EDGE] ? cap_edge_r : cap_edge_f);
      if (cap_event) begin
         next_st.cap = st.cnt;
         set_flags[`TMR16_FLAG_ICF] = 1'b1;
      end

      // ------------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------------
      if (WR_IN) begin
         case (ADDR_IN)
            `TMR16_OFS_CTRL_A: next_st.ctrl_a = WDATA_IN;
            `TMR16_OFS_CTRL_B: next_st.ctrl_b = WDATA_IN;
            `TMR16_OFS_CTRL_C: next_st.ctrl_c = {3'h0, WDATA_IN[4:0]};
            `TMR16_OFS_CNT_H, `TMR16_OFS_CAP_H: next_st.temp = WDATA_IN;
            `TMR16_OFS_CNT_L: begin
               // A written count suppresses the match on the next tick.
               next_st.cnt = {st.temp, WDATA_IN};
               next_st.block = 1'b1;
            end
            `TMR16_OFS_CAP_L: next_st.cap = {st.temp, WDATA_IN};
            `TMR16_OFS_MASK: next_st.mask = WDATA_IN & `TMR16_FLAG_USED;
            `TMR16_OFS_FLAG: clr_flags = WDATA_IN;
            `TMR16_OFS_POWER: next_st.power_gate = WDATA_IN[`TMR16_POWER_GATE];
            default: begin
               if (oc_hit && ADDR_IN[0]) begin
                  next_st.temp = WDATA_IN;
               end else if (oc_hit) begin
                  next_st.ocr_buf[oc_idx] = {st.temp, WDATA_IN};
                  if (!pwm) begin
                     next_st.ocr_act[oc_idx] = {st.temp, WDATA_IN};
                  end
               end
            end
         endcase
      end

      // A hardware set in the same cycle as a software clear wins.
      next_st.flags = ((st.flags & ~clr_flags) | set_flags) & `TMR16_FLAG_USED;
      next_st.irq = next_st.flags & st.mask;

      // ------------------------------------------------------------------
      // Register reads
      // ------------------------------------------------------------------
      next_st.rdata = 8'h00;
      if (RD_IN) begin
         case (ADDR_IN)
            `TMR16_OFS_CTRL_A: next_st.rdata = st.ctrl_a;
            `TMR16_OFS_CTRL_B: next_st.rdata = st.ctrl_b;
            `TMR16_OFS_CTRL_C: next_st.rdata = st.ctrl_c;
            `TMR16_OFS_CNT_L: begin
               next_st.rdata = st.cnt[7:0];
               next_st.temp = st.cnt[15:8];
            end
            `TMR16_OFS_CAP_L: begin
               next_st.rdata = st.cap[7:0];
               next_st.temp = st.cap[15:8];
            end
            `TMR16_OFS_CNT_H, `TMR16_OFS_CAP_H: next_st.rdata = st.temp;
            `TMR16_OFS_MASK: next_st.rdata = st.mask;
            `TMR16_OFS_FLAG: next_st.rdata = st.flags;
            `TMR16_OFS_POWER: next_st.rdata = {7'h00, st.power_gate};
            default: begin
               // Compare values read straight from the buffer, both bytes,
               // and leave the temporary register alone.
               if (oc_hit) begin
                  next_st.rdata = ADDR_IN[0] ? st.ocr_buf[oc_idx][15:8]
                     : st.ocr_buf[oc_idx][7:0];
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st <= '0;
         st.power_gate <= `TMR16_RST_POWER;
      end else begin
         st <= next_st;
      end
   end

   assign RDATA_OUT = st.rdata;
   assign COMPARE_OUTPUT_PINS_OUT = st.wave;
   assign IRQ_REQ_OUT = st.irq;

endmodule // tmr16_core

// ==== common/tmr16_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the
// 16-bit timer core. Definitions only; included by bare name.
`ifndef TMR16_DEFINES_SVH
`define TMR16_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port; TMR16_OFS_OCR_BASE is matched against ADDR_IN[7:3])
// ----------------------------------------------------------------------
`define TMR16_OFS_CTRL_A 8'h00
`define TMR16_OFS_CTRL_B 8'h01
`define TMR16_OFS_CTRL_C 8'h02
`define TMR16_OFS_CNT_L 8'h04
`define TMR16_OFS_CNT_H 8'h05
`define TMR16_OFS_CAP_L 8'h06
`define TMR16_OFS_CAP_H 8'h07
`define TMR16_OFS_OCR_BASE 5'h01
`define TMR16_OFS_MASK 8'h0e
`define TMR16_OFS_FLAG 8'h0f
`define TMR16_OFS_POWER 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMR16_CA_WGM_LO 1:0
`define TMR16_CB_WGM_HI 4:3
`define TMR16_CB_CS 2:0
`define TMR16_CB_CAP_SRC 5
`define TMR16_CB_CAP_EDGE 6
`define TMR16_CB_CAP_NC 7
`define TMR16_CC_FORCE 7:5
`define TMR16_FLAG_TOV 0
`define TMR16_FLAG_OCF0 1
`define TMR16_FLAG_ICF 5
`define TMR16_FLAG_USED 8'h2f
`define TMR16_POWER_GATE 0

// ----------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------
`define TMR16_RST_BYTE 8'h00
`define TMR16_RST_WORD 16'h0000
`define TMR16_RST_POWER 1'b0
`define TMR16_BOTTOM 16'h0000
`define TMR16_MAX 16'hffff
`define TMR16_TOP_8BIT 16'h00ff
`define TMR16_TOP_9BIT 16'h01ff
`define TMR16_TOP_10BIT 16'h03ff

// ----------------------------------------------------------------------
// Clock select codes and timing counts
// ----------------------------------------------------------------------
`define TMR16_CS_STOP 3'h0
`define TMR16_CS_DIV1 3'h1
`define TMR16_CS_DIV8 3'h2
`define TMR16_CS_DIV64 3'h3
`define TMR16_CS_DIV256 3'h4
`define TMR16_CS_DIV1024 3'h5
`define TMR16_CS_EXT_FALL 3'h6
`define TMR16_CS_EXT_RISE 3'h7
`define TMR16_NC_CYCLES 2'h3

`endif

// ==== common/tmr16_pkg.sv ====
// Types shared by the timer core and its pin filter.
// Assumes the constants header is available on the include path.
package tmr16_pkg;

   typedef enum logic [2:0] {
      TOP_MAX,
      TOP_8BIT,
      TOP_9BIT,
      TOP_10BIT,
      TOP_OCA,
      TOP_CAP
   } tmr16_top_e;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic [1:0] cnt;
      logic rise;
      logic fall;
   } tmr16_filt_s;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] ctrl_c;
      logic [7:0] mask;
      logic [7:0] flags;
      logic power_gate;
      logic [7:0] temp;
      logic [15:0] cnt;
      logic [15:0] cap;
      logic [2:0][15:0] ocr_buf;
      logic [2:0][15:0] ocr_act;
      logic [9:0] presc;
      logic block;
      logic [2:0] wave;
      logic [7:0] rdata;
      logic [7:0] irq;
   } tmr16_state_s;

endpackage

// ==== verilog/tmr16_pin_filter.sv ====
// Synchroniser and optional noise canceler for one timer input pin.
// Assumes the pin is asynchronous to CLK; edges come out as one-cycle pulses.
`timescale 1ns/1ps
`include "tmr16_defines.svh"

module tmr16_pin_filter (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic pin_in,
   input wire logic filter_en_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);

   tmr16_pkg::tmr16_filt_s st;
   tmr16_pkg::tmr16_filt_s next_st;

   // A change counts only once the second and third stage agree; with the
   // canceler on it must also hold for several further samples.
   always_comb begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.rise = 1'b0;
      next_st.fall = 1'b0;
      if ((st.s2 == st.s3) && (st.s3 != st.level)) begin
         if (!filter_en_in || (st.cnt == `TMR16_NC_CYCLES)) begin
            next_st.level = st.s3;
            next_st.rise = st.s3;
            next_st.fall = !st.s3;
            next_st.cnt = 2'h0;
         end else begin
            next_st.cnt = st.cnt + 2'h1;
         end
      end else begin
         next_st.cnt = 2'h0;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_out = st.level;
   assign rise_out = st.rise;
   assign fall_out = st.fall;

endmodule // tmr16_pin_filter

// ==== testbench/tmr16_core_chk.sv ====
// Assertions on the ports of the 16-bit timer core.
// Assumes one clock domain and the byte map of the defines header.
`timescale 1ns/1ps
`include "tmr16_defines.svh"
module tmr16_core_chk (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic [2:0] COMPARE_OUTPUT_PINS_OUT,
   input wire logic [7:0] IRQ_REQ_OUT
);
   logic [7:0] ca;
   logic [7:0] cb;
   logic [7:0] mk;
   logic [2:0] quiet;
   logic [3:0] mode;
   default clocking clk_def @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   // ------------------------------------------------------------
   // Shadow control bytes; quiet counts idle cycles with no clock.
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ca <= 8'h00;
         cb <= 8'h00;
         mk <= 8'h00;
         quiet <= 3'h0;
      end else begin
         if (WR_IN && ADDR_IN == `TMR16_OFS_CTRL_A) ca <= WDATA_IN;
         if (WR_IN && ADDR_IN == `TMR16_OFS_CTRL_B) cb <= WDATA_IN;
         if (WR_IN && ADDR_IN == `TMR16_OFS_MASK) mk <= WDATA_IN;
         if (WR_IN || cb[2:0] != 3'h0) quiet <= 3'h0;
         else if (quiet != 3'h7) quiet <= quiet + 3'h1;
      end
   end
   assign mode = {cb[4:3], ca[1:0]};
   sequence s_wr(logic [7:0] a);
      WR_IN && ADDR_IN == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      RD_IN && ADDR_IN == a;
   endsequence
   a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
      else $error("read data not zero outside a read");
   a_irq_unused: assert property ((IRQ_REQ_OUT & ~`TMR16_FLAG_USED) == 8'h00)
      else $error("request on an unused bit");
   a_irq_gated: assert property (mk == 8'h00 && $past(mk) == 8'h00 |-> IRQ_REQ_OUT == 8'h00)
      else $error("request while its mask is clear");
   a_ctrl_direct: assert property (s_wr(`TMR16_OFS_CTRL_A) ##1 s_rd(`TMR16_OFS_CTRL_A)
      |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("control byte readback wrong");
   a_word_commit: assert property (s_wr(8'h09) ##1 s_wr(8'h08) ##1 s_rd(8'h08)
      ##1 s_rd(8'h09) |-> RDATA_OUT == $past(WDATA_IN, 2) ##1 RDATA_OUT == $past(WDATA_IN, 4))
      else $error("compare word not committed whole");
   a_cmp_direct: assert property (s_wr(8'h09) ##1 s_wr(8'h08) ##1 s_wr(8'h05)
      ##1 s_rd(8'h09) |=> RDATA_OUT == $past(WDATA_IN, 4)) else $error("compare high used temp");
   a_temp_latch: assert property (quiet >= 3'h2 ##0 s_wr(8'h05) ##1 s_wr(8'h04)
      ##1 s_rd(8'h04) ##1 s_rd(8'h05)
      |-> RDATA_OUT == $past(WDATA_IN, 2) ##1 RDATA_OUT == $past(WDATA_IN, 4))
      else $error("count high not taken from latched temp");
   a_stop_holds: assert property (quiet >= 3'h4
      |=> (IRQ_REQ_OUT[3:0] & ~$past(IRQ_REQ_OUT[3:0])) == 4'h0) else $error("stopped timer moved");
   a_pwm_top_a: assert property ((mode == 4'hf) [*3] |-> COMPARE_OUTPUT_PINS_OUT[0] == 1'b0)
      else $error("channel A drives while it holds TOP");
endmodule // tmr16_core_chk

bind tmr16_core tmr16_core_chk chk (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
   .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .COMPARE_OUTPUT_PINS_OUT(COMPARE_OUTPUT_PINS_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT));

// ==== testbench/tmr16_host_model.sv ====
// Host CPU on the byte-wide register port of the timer core.
// Assumes each task is entered right after a rising clock edge.
`timescale 1ns/1ps
`include "tmr16_defines.svh"
module tmr16_host_model (
   input wire logic clk_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // ------------------------------------------------------------
   // Strobes stay up until the next call so accesses run back to back.
   // ------------------------------------------------------------
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      wr_out <= w;
      rd_out <= r;
      addr_out <= a;
      wdata_out <= w ? d : ~wdata_out;
      @(posedge clk_in);
   endtask
   task automatic idle(input int n);
      op(1'b0, 1'b0, ~addr_out, 8'h00);
      repeat (n - 1) @(posedge clk_in);
   endtask
   task automatic power_up();
      op(1'b1, 1'b0, `TMR16_OFS_POWER, 8'h00);
   endtask
   // Both halves go out with nothing in between, so no other access can disturb temp.
   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      op(1'b1, 1'b0, a + 8'h01, v[15:8]);
      op(1'b1, 1'b0, a, v[7:0]);
   endtask
   task automatic r16(input logic [7:0] a);
      op(1'b0, 1'b1, a, 8'h00);
      op(1'b0, 1'b1, a + 8'h01, 8'h00);
   endtask
endmodule // tmr16_host_model

// ==== testbench/test_sixteen_bit_timer_core_access.sv ====
// Self-checking bench of the timer core: registers, counting, capture, outputs.
// Assumes the host model drives the register port and this module the pins.
`timescale 1ns/1ps
`include "tmr16_defines.svh"
module test_sixteen_bit_timer_core_access;
   logic clk, nrst, ext, cap, cmp, wr, rd, rd_q;
   logic [7:0] addr, wdata, rdata, irq;
   logic [2:0] pins;
   logic [15:0] seed, v, cv;
   logic [7:0] expq[$];
   int failures, comparisons;
   tmr16_core DUT (.CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .EXT_COUNT_INPUT_IN(ext), .CAPTURE_INPUT_PIN_IN(cap), .COMPARATOR_IN(cmp),
      .RDATA_OUT(rdata), .COMPARE_OUTPUT_PINS_OUT(pins), .IRQ_REQ_OUT(irq));
   tmr16_host_model host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd));
   initial clk = 1'b0;
   always #20 clk = ~clk;
   // ------------------------------------------------------------
   // Checking and helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] e);
      comparisons++;
      if (got !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   // Read data stand only in the cycle after the strobe, so compare there.
   always @(posedge clk) begin
      if (rd_q) check(rdata, expq.size() != 0 ? expq.pop_front() : 8'hxx);
      rd_q = rd;
   end
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   task automatic report_and_stop();
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      host.op(1'b1, 1'b0, a, d);
   endtask
   task automatic rd8(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.op(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e);
      expq.push_back(e[7:0]);
      expq.push_back(e[15:8]);
      host.r16(a);
   endtask
   task automatic drive_src(input logic [7:0] b, input logic l);
      if (b[5]) cmp <= l;
      else cap <= l;
   endtask
   // Waits for an interrupt bit, or for a change of output A when b is 8.
   task automatic wait_bit(input int b);
      logic old;
      host.idle(1);
      old = pins[0];
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         if (b == 8 ? pins[0] !== old : irq[b] === 1'b1) begin
            comparisons++;
            return;
         end
      end
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, irq, 8'hff);
      report_and_stop();
   endtask
   initial begin
      logic [15:0] tops [4];
      logic [7:0] cbs [4];
      tops = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};
      cbs = '{8'h40, 8'hc0, 8'h60, 8'h20};
      seed = 16'h90f8;
      {nrst, ext, cap, cmp} = 4'h0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      host.power_up();
      for (int a = 0; a < 17; a++) rd8(8'(a), 8'h00);
      wr8(8'h11, 8'hff);
      rd8(8'h11, 8'h00);
      v = rnd();
      wr8(`TMR16_OFS_CTRL_A, v[7:0]);
      rd8(`TMR16_OFS_CTRL_A, v[7:0]);
      wr8(`TMR16_OFS_CTRL_C, v[15:8]);
      rd8(`TMR16_OFS_CTRL_C, v[15:8] & 8'h1f);
      wr8(`TMR16_OFS_CTRL_A, 8'h00);
      host.idle(3);
      $display("Test registers done");
      for (int k = 2; k < 7; k++) begin
         v = rnd();
         if (k == 2) cv = v;
         host.w16(8'(2 * k), v);
         rd16(8'(2 * k), v);
      end
      v = rnd();
      host.w16(8'h08, v);
      wr8(`TMR16_OFS_CNT_H, ~v[15:8]);
      rd8(8'h09, v[15:8]);
      rd16(`TMR16_OFS_CNT_L, cv);
      $display("Test words done");
      for (int k = 8; k < 14; k += 2) host.w16(8'(k), 16'hffff);
      for (int m = 0; m < 4; m++) begin
         wr8(`TMR16_OFS_CTRL_A, 8'(m));
         host.w16(`TMR16_OFS_CNT_L, tops[m] - 16'h0002);
         wr8(`TMR16_OFS_FLAG, 8'h2f);
         wr8(`TMR16_OFS_MASK, 8'h01);
         wr8(`TMR16_OFS_CTRL_B, {5'h00, `TMR16_CS_DIV1});
         wait_bit(0);
         wr8(`TMR16_OFS_CTRL_B, 8'h00);
         rd8(`TMR16_OFS_FLAG, m == 0 ? 8'h0f : 8'h01);
      end
      wr8(`TMR16_OFS_CTRL_A, 8'h00);
      $display("Test overflow done");
      for (int c = 0; c < 4; c++) begin
         cv = rnd();
         drive_src(cbs[c], ~cbs[c][6]);
         host.idle(8);
         host.w16(`TMR16_OFS_CNT_L, cv);
         wr8(`TMR16_OFS_CTRL_B, cbs[c]);
         wr8(`TMR16_OFS_FLAG, 8'h2f);
         wr8(`TMR16_OFS_MASK, 8'h20);
         if (cbs[c][7]) begin
            // A two-cycle spike gets through the synchroniser but not the canceler.
            drive_src(cbs[c], cbs[c][6]);
            host.idle(2);
            drive_src(cbs[c], ~cbs[c][6]);
            host.idle(12);
            check(irq, 8'h00);
         end
         drive_src(cbs[c], cbs[c][6]);
         wait_bit(5);
         rd16(`TMR16_OFS_CAP_L, cv);
      end
      wr8(`TMR16_OFS_MASK, 8'h00);
      $display("Test capture done");
      for (int s = 6; s < 8; s++) begin
         cv = rnd();
         host.w16(`TMR16_OFS_CNT_L, cv);
         wr8(`TMR16_OFS_CTRL_B, 8'(s));
         host.idle(8);
         repeat (3) begin
            ext <= 1'b1;
            host.idle(int'(rnd() & 16'h0007) + 4);
            ext <= 1'b0;
            host.idle(int'(rnd() & 16'h0007) + 4);
         end
         wr8(`TMR16_OFS_CTRL_B, 8'h00);
         host.idle(20);
         rd16(`TMR16_OFS_CNT_L, cv + 16'h0003);
      end
      $display("Test external clock done");
      cv = rnd();
      host.w16(`TMR16_OFS_CNT_L, cv);
      wr8(`TMR16_OFS_POWER, 8'h01);
      wr8(`TMR16_OFS_CTRL_B, {5'h00, `TMR16_CS_DIV1});
      host.idle(8);
      rd8(`TMR16_OFS_POWER, 8'h01);
      rd16(`TMR16_OFS_CNT_L, cv);
      wr8(`TMR16_OFS_POWER, 8'h00);
      host.idle(4);
      wr8(`TMR16_OFS_CTRL_B, 8'h00);
      // Five ticks land between the gate release and the stop write.
      rd16(`TMR16_OFS_CNT_L, cv + 16'h0005);
      $display("Test power gate done");
      host.w16(8'h08, 16'h0010);
      host.w16(`TMR16_OFS_CNT_L, 16'h0000);
      wr8(`TMR16_OFS_CTRL_A, 8'h40);
      wr8(`TMR16_OFS_CTRL_B, 8'h09);
      wait_bit(8);
      wait_bit(8);
      wr8(`TMR16_OFS_CTRL_A, 8'h83);
      wr8(`TMR16_OFS_CTRL_B, 8'h19);
      host.idle(40);
      check({5'h00, pins}, 8'h00);
      wr8(`TMR16_OFS_CTRL_B, 8'h00);
      host.idle(4);
      $display("Test outputs done");
      report_and_stop();
   end
endmodule // test_sixteen_bit_timer_core_access
